// ==== rtl/bpr_pkg.sv ====
/*
  Shared constants for the bank precharge and refresh logic: command
  encodings, address fields, bank states and timing counts.
  Assumes a 100 MHz clock; the timing counts given in ns are derived from it.
*/
package bpr_pkg;

  // ----------------------------------------------------------------
  // Geometry and address fields
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 13;
  localparam int ADDR_BIT_TEN_SELECT = 10;
  localparam int BURST_LEN = 4;

  // ----------------------------------------------------------------
  // Commands as {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_INHIBIT = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_AUTO_REFRESH = 4'h1;

  // ----------------------------------------------------------------
  // Timing in ns and derived cycle counts (least times round up)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRECHARGE_PERIOD_TIME_NS = 15;
  localparam int ROW_ACTIVE_MIN_TIME_NS = 40;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 15;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int REFRESH_CYCLE_TIME_NS = 72;
  localparam int DQSS_CYC = 1;
  localparam int CNT_W = 8;

  localparam logic [CNT_W-1:0] RP_CYC =
    CNT_W'((PRECHARGE_PERIOD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RAS_CYC =
    CNT_W'((ROW_ACTIVE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RCD_CYC =
    CNT_W'((ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WR_CYC =
    CNT_W'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RFC_CYC =
    CNT_W'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Command to internal precharge start for auto precharge
  localparam logic [CNT_W-1:0] RD_AP_CYC = CNT_W'(BURST_LEN / 2);
  localparam logic [CNT_W-1:0] WR_AP_CYC =
    CNT_W'(DQSS_CYC + BURST_LEN / 2) + WR_CYC;
  // Spacing between column commands to keep the data bus clean
  localparam logic [CNT_W-1:0] COL_GAP_CYC = CNT_W'(BURST_LEN / 2 + 2);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BPR_BK_IDLE = 2'b00,
    BPR_BK_OPEN = 2'b01,
    BPR_BK_AP_ACCESS = 2'b10,
    BPR_BK_PRECHARGING = 2'b11
  } bpr_bank_t;

  typedef enum logic [2:0] {
    BPR_OP_ACTIVE = 3'b000,
    BPR_OP_READ = 3'b001,
    BPR_OP_WRITE = 3'b010,
    BPR_OP_PRE_ONE = 3'b011,
    BPR_OP_PRE_ALL = 3'b100,
    BPR_OP_REFRESH = 3'b101
  } bpr_op_t;

endpackage

// ==== rtl/bpr_cmd_if.sv ====
/*
  Command and address bus between the memory controller and the device.
  Assumes both ends share one clock; commands are sampled on its rising edge.
*/
`timescale 1ns/10ps
interface bpr_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic bank_select_lsb;
  logic bank_select_msb;
  logic [bpr_pkg::ADDR_W-1:0] addr;

  modport ctl (
    output cs_n, ras_n, cas_n, we_n, cke, bank_select_lsb, bank_select_msb, addr
  );
  modport dev (
    input cs_n, ras_n, cas_n, we_n, cke, bank_select_lsb, bank_select_msb, addr
  );
endinterface

// ==== rtl/bpr_dev.sv ====
/*
  Device end: per-bank row state, explicit precharge, auto precharge with row
  active lock-out, and auto refresh with an internal row counter.
  Assumes the controller drives the command bus synchronously to clock.
*/
`timescale 1ns/10ps
module bpr_dev (
  input wire logic clock, // 100 MHz clock
  input wire logic resetn, // Asynchronous reset, active low
  bpr_cmd_if.dev bus, // Command and address bus
  output logic [bpr_pkg::NUM_BANKS-1:0] bank_open, // Row open in bank
  output logic [bpr_pkg::NUM_BANKS-1:0] bank_precharging, // Bank in precharge
  output logic [bpr_pkg::NUM_BANKS-1:0] ap_pending, // Auto precharge armed
  output logic refresh_busy, // Refresh cycle in progress
  output logic [bpr_pkg::ADDR_W-1:0] refresh_row_q, // Last refreshed row
  output logic refresh_pulse_q, // One cycle per refresh taken
  output logic cmd_error_q // One cycle on illegal access
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic [1:0] bank_sel;
  logic bit_ten;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_ref;
  logic [bpr_pkg::NUM_BANKS-1:0] bank_idle;
  logic [bpr_pkg::NUM_BANKS-1:0] bank_active;

  assign cmd = bus.cke ? {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} : bpr_pkg::CMD_INHIBIT;
  assign bank_sel = {bus.bank_select_msb, bus.bank_select_lsb};
  assign bit_ten = bus.addr[bpr_pkg::ADDR_BIT_TEN_SELECT];
  assign is_act = (cmd == bpr_pkg::CMD_ACTIVE);
  assign is_rd = (cmd == bpr_pkg::CMD_READ);
  assign is_wr = (cmd == bpr_pkg::CMD_WRITE);
  assign is_pre = (cmd == bpr_pkg::CMD_PRECHARGE);
  assign is_ref = (cmd == bpr_pkg::CMD_AUTO_REFRESH);

  // ----------------------------------------------------------------
  // Per-bank state machines
  // ----------------------------------------------------------------
  for (genvar b = 0; b < bpr_pkg::NUM_BANKS; b++) begin : g_bank
    bpr_pkg::bpr_bank_t st_q;
    logic [bpr_pkg::CNT_W-1:0] ras_q;
    logic [bpr_pkg::CNT_W-1:0] acc_q;
    logic [bpr_pkg::CNT_W-1:0] rp_q;
    logic hit;
    logic pre_hit;
    logic col_hit;

    assign hit = (bank_sel == 2'(b));
    // Bank select is a don't-care for the all-bank form
    assign pre_hit = is_pre && (bit_ten || hit);
    assign col_hit = (is_rd || is_wr) && hit;

    // Row active lock-out timer, loaded on activate
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        ras_q <= '0;
      end else if (bank_idle[b] && is_act && hit) begin
        ras_q <= bpr_pkg::RAS_CYC;
      end else if (ras_q != '0) begin
        ras_q <= ras_q - 1'b1;
      end
    end

    // Access period countdown to the internal precharge point
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        acc_q <= '0;
      end else if (st_q == bpr_pkg::BPR_BK_OPEN && col_hit && bit_ten) begin
        acc_q <= is_rd ? bpr_pkg::RD_AP_CYC : bpr_pkg::WR_AP_CYC;
      end else if (acc_q != '0) begin
        acc_q <= acc_q - 1'b1;
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        st_q <= bpr_pkg::BPR_BK_IDLE;
        rp_q <= '0;
      end else begin
        case (st_q)
          bpr_pkg::BPR_BK_IDLE: begin
            // Precharge here is a no-op
            if (is_act && hit) begin
              st_q <= bpr_pkg::BPR_BK_OPEN;
            end
          end
          bpr_pkg::BPR_BK_OPEN: begin
            if (pre_hit) begin
              st_q <= bpr_pkg::BPR_BK_PRECHARGING;
              rp_q <= bpr_pkg::RP_CYC - 1'b1;
            end else if (col_hit && bit_ten) begin
              // Armed for this command only; plain column commands leave it clear
              st_q <= bpr_pkg::BPR_BK_AP_ACCESS;
            end
          end
          bpr_pkg::BPR_BK_AP_ACCESS: begin
            // Counts expire on this edge: burst end, or write recovery end for writes, never before row time
            if (acc_q <= 8'h01 && ras_q <= 8'h01) begin
              st_q <= bpr_pkg::BPR_BK_PRECHARGING;
              rp_q <= bpr_pkg::RP_CYC - 1'b1;
            end
          end
          bpr_pkg::BPR_BK_PRECHARGING: begin
            // Further precharges are no-ops
            // Precharge period over: an activate on this edge is taken
            if (rp_q == '0) begin
              st_q <= (is_act && hit) ? bpr_pkg::BPR_BK_OPEN : bpr_pkg::BPR_BK_IDLE;
            end else begin
              rp_q <= rp_q - 1'b1;
            end
          end
          default: begin
            st_q <= bpr_pkg::BPR_BK_IDLE;
          end
        endcase
      end
    end

    assign bank_idle[b] = (st_q == bpr_pkg::BPR_BK_IDLE) ||
                          (st_q == bpr_pkg::BPR_BK_PRECHARGING && rp_q == '0);
    assign bank_active[b] = (st_q == bpr_pkg::BPR_BK_OPEN);
    assign bank_open[b] = (st_q == bpr_pkg::BPR_BK_OPEN) ||
                          (st_q == bpr_pkg::BPR_BK_AP_ACCESS);
    assign bank_precharging[b] = (st_q == bpr_pkg::BPR_BK_PRECHARGING);
    assign ap_pending[b] = (st_q == bpr_pkg::BPR_BK_AP_ACCESS);
  end

  // ----------------------------------------------------------------
  // Illegal access flag
  // ----------------------------------------------------------------
  // Column access needs an open row in its own bank; other banks may be
  // in any state, so concurrent auto precharge is not an error
  logic col_bad;
  logic ref_bad;

  assign col_bad = (is_rd || is_wr) && !bank_active[bank_sel];
  assign ref_bad = is_ref && (bank_idle != {bpr_pkg::NUM_BANKS{1'b1}});

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_error_q <= 1'b0;
    end else begin
      // Deselect (chip select high) and inhibit are both allowed during refresh
      cmd_error_q <= col_bad || ref_bad || (refresh_busy && cmd != bpr_pkg::CMD_NOP &&
                     !cmd[3]);
    end
  end

  // ----------------------------------------------------------------
  // Auto refresh
  // ----------------------------------------------------------------
  logic [bpr_pkg::CNT_W-1:0] rfc_q;

  assign refresh_busy = (rfc_q != '0);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rfc_q <= '0;
    end else if (is_ref && !refresh_busy) begin
      rfc_q <= bpr_pkg::RFC_CYC;
    end else if (rfc_q != '0) begin
      rfc_q <= rfc_q - 1'b1;
    end
  end

  // Row comes from the internal counter; address inputs are ignored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refresh_row_q <= '0;
      refresh_pulse_q <= 1'b0;
    end else begin
      refresh_pulse_q <= is_ref && !refresh_busy;
      if (is_ref && !refresh_busy) begin
        refresh_row_q <= refresh_row_q + 1'b1;
      end
    end
  end

endmodule

// ==== rtl/bpr_ctl.sv ====
/*
  Controller end: takes one request at a time from the user, holds it off
  until every bank and refresh timing allows it (write recovery only before auto precharge), and drives the command bus.
  Assumes the user keeps a request stable until it is taken.
*/
`timescale 1ns/10ps
module bpr_ctl (
  input wire logic clock, // 100 MHz clock
  input wire logic resetn, // Asynchronous reset, active low
  bpr_cmd_if.ctl bus, // Command and address bus
  input wire logic req_valid, // Request present
  input wire bpr_pkg::bpr_op_t req_op, // Requested operation
  input wire logic [1:0] req_bank, // Target bank
  input wire logic [bpr_pkg::ADDR_W-1:0] req_addr, // Row or column address
  input wire logic req_ap, // Auto precharge on read or write
  output logic req_ready, // Request taken this cycle when valid
  output logic all_idle // No bank open or recovering
);

  // ----------------------------------------------------------------
  // Bank bookkeeping
  // ----------------------------------------------------------------
  logic [bpr_pkg::NUM_BANKS-1:0] open_q;
  logic [bpr_pkg::CNT_W-1:0] rcd_q [bpr_pkg::NUM_BANKS];
  logic [bpr_pkg::CNT_W-1:0] ras_q [bpr_pkg::NUM_BANKS];
  logic [bpr_pkg::CNT_W-1:0] busy_q [bpr_pkg::NUM_BANKS];
  logic [bpr_pkg::CNT_W-1:0] acc_q;
  logic [bpr_pkg::CNT_W-1:0] col_q;
  logic [bpr_pkg::CNT_W-1:0] rfc_q;
  logic fire;
  logic is_col;
  logic [bpr_pkg::CNT_W-1:0] ap_dly;
  logic all_ready;

  assign fire = req_valid && req_ready;
  assign is_col = (req_op == bpr_pkg::BPR_OP_READ) || (req_op == bpr_pkg::BPR_OP_WRITE);
  assign ap_dly = (req_op == bpr_pkg::BPR_OP_READ) ? bpr_pkg::RD_AP_CYC : bpr_pkg::WR_AP_CYC;

  always_comb begin
    all_ready = 1'b1;
    for (int i = 0; i < bpr_pkg::NUM_BANKS; i++) begin
      if (busy_q[i] != '0 || (open_q[i] && ras_q[i] != '0)) begin
        all_ready = 1'b0;
      end
    end
  end

  assign all_idle = all_ready && (open_q == '0);

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  always_comb begin
    req_ready = 1'b0;
    if (rfc_q == '0) begin
      case (req_op)
        bpr_pkg::BPR_OP_ACTIVE: req_ready = !open_q[req_bank] && busy_q[req_bank] == '0;
        bpr_pkg::BPR_OP_READ,
        bpr_pkg::BPR_OP_WRITE: begin
          // Other banks' access periods block column commands
          req_ready = open_q[req_bank] && busy_q[req_bank] == '0 &&
                      rcd_q[req_bank] == '0 && acc_q == '0 && col_q == '0;
        end
        bpr_pkg::BPR_OP_PRE_ONE: req_ready = busy_q[req_bank] == '0 && ras_q[req_bank] == '0;
        bpr_pkg::BPR_OP_PRE_ALL: req_ready = all_ready;
        bpr_pkg::BPR_OP_REFRESH: req_ready = all_idle;
        default: req_ready = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      open_q <= '0;
      for (int i = 0; i < bpr_pkg::NUM_BANKS; i++) begin
        rcd_q[i] <= '0;
        ras_q[i] <= '0;
        busy_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < bpr_pkg::NUM_BANKS; i++) begin
        if (rcd_q[i] != '0) rcd_q[i] <= rcd_q[i] - 1'b1;
        if (ras_q[i] != '0) ras_q[i] <= ras_q[i] - 1'b1;
        if (busy_q[i] != '0) busy_q[i] <= busy_q[i] - 1'b1;
        if (fire && (req_bank == 2'(i) || req_op == bpr_pkg::BPR_OP_PRE_ALL)) begin
          if (req_op == bpr_pkg::BPR_OP_ACTIVE) begin
            open_q[i] <= 1'b1;
            rcd_q[i] <= bpr_pkg::RCD_CYC;
            ras_q[i] <= bpr_pkg::RAS_CYC;
          end else if ((req_op == bpr_pkg::BPR_OP_PRE_ONE ||
                        req_op == bpr_pkg::BPR_OP_PRE_ALL) && open_q[i]) begin
            open_q[i] <= 1'b0;
            busy_q[i] <= bpr_pkg::RP_CYC;
          end else if (is_col && req_ap) begin
            // Bank closes itself; wait for access, lock-out and precharge
            open_q[i] <= 1'b0;
            busy_q[i] <= ((ap_dly > ras_q[i]) ? ap_dly : ras_q[i]) + bpr_pkg::RP_CYC;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
      col_q <= '0;
      rfc_q <= '0;
    end else begin
      acc_q <= (fire && is_col && req_ap) ? ap_dly : (acc_q != '0 ? acc_q - 1'b1 : acc_q);
      col_q <= (fire && is_col) ? bpr_pkg::COL_GAP_CYC : (col_q != '0 ? col_q - 1'b1 : col_q);
      if (fire && req_op == bpr_pkg::BPR_OP_REFRESH) begin
        rfc_q <= bpr_pkg::RFC_CYC;
      end else if (rfc_q != '0) begin
        rfc_q <= rfc_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command bus drive
  // ----------------------------------------------------------------
  logic [3:0] cmd_q;
  logic [1:0] ba_q;
  logic [bpr_pkg::ADDR_W-1:0] addr_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= bpr_pkg::CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
    end else if (fire) begin
      ba_q <= req_bank;
      addr_q <= req_addr;
      case (req_op)
        bpr_pkg::BPR_OP_ACTIVE: cmd_q <= bpr_pkg::CMD_ACTIVE;
        bpr_pkg::BPR_OP_READ: begin
          cmd_q <= bpr_pkg::CMD_READ;
          addr_q[bpr_pkg::ADDR_BIT_TEN_SELECT] <= req_ap;
        end
        bpr_pkg::BPR_OP_WRITE: begin
          cmd_q <= bpr_pkg::CMD_WRITE;
          addr_q[bpr_pkg::ADDR_BIT_TEN_SELECT] <= req_ap;
        end
        bpr_pkg::BPR_OP_PRE_ONE: begin
          cmd_q <= bpr_pkg::CMD_PRECHARGE;
          addr_q[bpr_pkg::ADDR_BIT_TEN_SELECT] <= 1'b0;
        end
        bpr_pkg::BPR_OP_PRE_ALL: begin
          cmd_q <= bpr_pkg::CMD_PRECHARGE;
          addr_q[bpr_pkg::ADDR_BIT_TEN_SELECT] <= 1'b1;
        end
        bpr_pkg::BPR_OP_REFRESH: cmd_q <= bpr_pkg::CMD_AUTO_REFRESH;
        default: cmd_q <= bpr_pkg::CMD_NOP;
      endcase
    end else begin
      cmd_q <= bpr_pkg::CMD_NOP; // Clock keeps running between commands
    end
  end

  assign bus.cs_n = cmd_q[3];
  assign bus.ras_n = cmd_q[2];
  assign bus.cas_n = cmd_q[1];
  assign bus.we_n = cmd_q[0];
  assign bus.cke = 1'b1;
  assign bus.bank_select_lsb = ba_q[0];
  assign bus.bank_select_msb = ba_q[1];
  assign bus.addr = addr_q;

endmodule

// ==== test/bpr_asserts.sv ====
/*
  Assertions on the command bus joining controller and device, and on the
  state outputs of that device. Assumes one clock and the first pair only.
*/
`timescale 1ns/10ps
module bpr_asserts (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic cs_n, // Chip select, active low
  input wire logic ras_n, // Row strobe, active low
  input wire logic cas_n, // Column strobe, active low
  input wire logic we_n, // Write enable, active low
  input wire logic cke, // Clock enable
  input wire logic bank_select_lsb, // Bank bit 0
  input wire logic bank_select_msb, // Bank bit 1
  input wire logic [bpr_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [3:0] bank_open, // Row open per bank
  input wire logic [3:0] bank_precharging, // Precharge per bank
  input wire logic [3:0] ap_pending, // Auto precharge armed
  input wire logic refresh_busy, // Refresh running
  input wire logic [bpr_pkg::ADDR_W-1:0] refresh_row_q, // Refreshed row
  input wire logic refresh_pulse_q, // Refresh taken
  input wire logic cmd_error_q // Illegal access seen
);
  // ----------------------------------------------------------------
  // Decode and sequences
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic [3:0] plain_open;
  logic [1:0] bk;
  logic col;
  logic bit_ten;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign bk = {bank_select_msb, bank_select_lsb};
  assign col = cmd == bpr_pkg::CMD_READ || cmd == bpr_pkg::CMD_WRITE;
  assign bit_ten = addr[bpr_pkg::ADDR_BIT_TEN_SELECT];
  assign plain_open = bank_open & ~ap_pending;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_ap0(logic [3:0] c);
    cmd == c && bit_ten && bk == 2'h0;
  endsequence
  sequence s_pre_run;
    ##1 bank_precharging[0] ##1 (!bank_precharging[0] && !bank_open[0]);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_PRE_ONE: assert property (
    cmd == bpr_pkg::CMD_PRECHARGE && !bit_ten && plain_open[bk]
    |=> bank_precharging[$past(bk)]) else $error("single precharge not started");
  AST_PRE_ALL: assert property (
    cmd == bpr_pkg::CMD_PRECHARGE && bit_ten
    |=> (bank_precharging & $past(plain_open)) == $past(plain_open))
    else $error("open bank missed by precharge all");
  AST_PRE_LEN: assert property (
    $rose(bank_precharging[0]) |-> s_pre_run) else $error("precharge length wrong");
  AST_ACT_IDLE: assert property (
    cmd == bpr_pkg::CMD_ACTIVE |-> !bank_open[bk] && !bank_precharging[bk])
    else $error("activate to busy bank");
  AST_COL_OPEN: assert property (
    col |-> plain_open[bk] && !cmd_error_q) else $error("column access to closed bank");
  AST_AP_ACCESS: assert property (
    |ap_pending |-> !col) else $error("column command in access period");
  AST_COL_GAP: assert property (
    col |=> !col [*3]) else $error("column commands too close");
  AST_RFC: assert property (
    refresh_busy |-> cs_n || cmd == bpr_pkg::CMD_NOP) else $error("command during refresh");
  AST_CKE: assert property (
    cke) else $error("clock enable dropped");
  AST_REF_IDLE: assert property (
    cmd == bpr_pkg::CMD_AUTO_REFRESH |-> bank_open == 4'h0 && bank_precharging == 4'h0)
    else $error("refresh with bank not idle");
  AST_REF_ROW: assert property (
    cmd == bpr_pkg::CMD_AUTO_REFRESH && !refresh_busy
    |=> refresh_pulse_q && refresh_row_q == $past(refresh_row_q) + 13'h0001)
    else $error("refresh row not advanced");
  AST_RD_AP: assert property (
    s_ap0(bpr_pkg::CMD_READ) |-> ##1 ap_pending[0] ##2 bank_precharging[0]
    ##2 (!bank_open[0] && !bank_precharging[0]))
    else $error("read auto precharge timing wrong");
  AST_WR_AP: assert property (
    s_ap0(bpr_pkg::CMD_WRITE) |-> ##5 ap_pending[0] ##1 bank_precharging[0]
    ##2 (!bank_open[0] && !bank_precharging[0]))
    else $error("write auto precharge timing wrong");
endmodule

// ==== test/testbench.sv ====
/*
  Testbench: a controller joined to a device, driven through user requests,
  and a second device driven directly on its bus. Assumes a 100 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------
  // Clock, reset and design instances
  // ----------------------------------------------------------------
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic req_valid = 1'h0;
  bpr_pkg::bpr_op_t req_op = bpr_pkg::BPR_OP_ACTIVE;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic req_ap = 1'h0;
  logic req_ready, all_idle, a_busy, a_pulse, a_err, b_busy, b_pulse, b_err;
  logic [3:0] a_open, a_pre, a_ap, b_open, b_pre, b_ap;
  logic [12:0] a_row, b_row;
  int err_count = 0;
  int num_checks = 0;
  bpr_cmd_if bus_a ();
  bpr_cmd_if bus_b ();
  always #5 clock = ~clock;

  bpr_ctl bpr_ctl_inst (.clock(clock), .resetn(resetn), .bus(bus_a), .req_valid(req_valid),
    .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr), .req_ap(req_ap),
    .req_ready(req_ready), .all_idle(all_idle));
  bpr_dev bpr_dev_inst (.clock(clock), .resetn(resetn), .bus(bus_a), .bank_open(a_open),
    .bank_precharging(a_pre), .ap_pending(a_ap), .refresh_busy(a_busy),
    .refresh_row_q(a_row), .refresh_pulse_q(a_pulse), .cmd_error_q(a_err));
  bpr_dev bpr_dev_inst2 (.clock(clock), .resetn(resetn), .bus(bus_b), .bank_open(b_open),
    .bank_precharging(b_pre), .ap_pending(b_ap), .refresh_busy(b_busy),
    .refresh_row_q(b_row), .refresh_pulse_q(b_pulse), .cmd_error_q(b_err));
  bpr_asserts bpr_asserts_inst (.clock(clock), .resetn(resetn), .cs_n(bus_a.cs_n),
    .ras_n(bus_a.ras_n), .cas_n(bus_a.cas_n), .we_n(bus_a.we_n), .cke(bus_a.cke),
    .bank_select_lsb(bus_a.bank_select_lsb), .bank_select_msb(bus_a.bank_select_msb),
    .addr(bus_a.addr), .bank_open(a_open), .bank_precharging(a_pre), .ap_pending(a_ap),
    .refresh_busy(a_busy), .refresh_row_q(a_row), .refresh_pulse_q(a_pulse),
    .cmd_error_q(a_err));

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One command on the second bus, then NOP; returns just after the sampling edge
  task automatic issue(logic [3:0] c, logic [1:0] b, logic [12:0] a);
    @(posedge clock);
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} <= c;
    {bus_b.bank_select_msb, bus_b.bank_select_lsb} <= b;
    bus_b.addr <= a;
    @(posedge clock);
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} <= bpr_pkg::CMD_NOP;
    bus_b.addr <= ~a;
    #1;
  endtask

  // One controller request held until taken, then the bus command is compared
  task automatic req(bpr_pkg::bpr_op_t op, logic [1:0] b, logic ap_en, logic [3:0] c,
                     logic t);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'h1;
    req_op <= op;
    req_bank <= b;
    req_ap <= ap_en;
    req_addr <= {2'h0, ap_en, 10'h155};
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'h1 && n < 100);
    req_valid <= 1'h0;
    #1;
    check({bus_a.cs_n, bus_a.ras_n, bus_a.cas_n, bus_a.we_n}, c);
    if (c != bpr_pkg::CMD_ACTIVE && c != bpr_pkg::CMD_AUTO_REFRESH)
      check(bus_a.addr[bpr_pkg::ADDR_BIT_TEN_SELECT], t);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = bpr_pkg::CMD_NOP;
    {bus_b.bank_select_msb, bus_b.bank_select_lsb} = 2'h0;
    bus_b.cke = 1'h1;
    bus_b.addr = 13'h0000;
    repeat (3) @(posedge clock);
    resetn <= 1'h1;
    for (int k = 0; k < 3; k++) issue(bpr_pkg::CMD_ACTIVE, 2'(k), 13'h0ABC);
    check(b_open, 4'h7);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h1, 13'h1BFF);
    check({b_pre, b_open}, 8'h25);
    step(2);
    check({b_pre, b_open}, 8'h05);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h1, 13'h0000);
    check({b_pre, b_open}, 8'h05);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h0, 13'h0000);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h0, 13'h0000);
    check({b_pre, b_open}, 8'h04);
    issue(bpr_pkg::CMD_READ, 2'h1, 13'h0000);
    check(b_err, 1'h1);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
    check({b_pre, b_open}, 8'h40);
    step(2);
    issue(bpr_pkg::CMD_AUTO_REFRESH, 2'h3, 13'h1FFF);
    check({b_busy, b_pulse, b_row}, 15'h6001);
    issue(bpr_pkg::CMD_PRECHARGE, 2'h0, 13'h0000);
    check({b_err, b_open}, 5'h10);
    step(5);
    check(b_busy, 1'h1);
    step(1);
    check(b_busy, 1'h0);
    issue(bpr_pkg::CMD_AUTO_REFRESH, 2'h0, 13'h0000);
    check({b_pulse, b_row}, 14'h2002);
    step(9);
    issue(bpr_pkg::CMD_ACTIVE, 2'h3, 13'h0000);
    issue(bpr_pkg::CMD_AUTO_REFRESH, 2'h0, 13'h0000);
    check({b_err, b_row}, 14'h2003);
    step(7);
    issue(bpr_pkg::CMD_ACTIVE, 2'h0, 13'h0000);
    issue(bpr_pkg::CMD_READ, 2'h0, 13'h0400);
    check({b_ap, b_pre, b_open}, 12'h109);
    issue(bpr_pkg::CMD_READ, 2'h3, 13'h0000);
    check({b_err, b_pre[0]}, 2'h1);
    step(2);
    check({b_ap[0], b_pre[0], b_open[0]}, 3'h0);
    issue(bpr_pkg::CMD_WRITE, 2'h3, 13'h0400);
    step(3);
    check({b_pre[3], b_open[3]}, 2'h1);
    step(2);
    check({b_pre[3], b_open[3]}, 2'h2);
    step(2);
    check({b_pre[3], b_open[3]}, 2'h0);
    issue(bpr_pkg::CMD_ACTIVE, 2'h3, 13'h0000);
    step(4);
    issue(bpr_pkg::CMD_READ, 2'h3, 13'h0000);
    step(6);
    check({b_open[3], b_ap[3]}, 2'h2);
    req(bpr_pkg::BPR_OP_ACTIVE, 2'h0, 1'h0, bpr_pkg::CMD_ACTIVE, 1'h0);
    req(bpr_pkg::BPR_OP_READ, 2'h0, 1'h1, bpr_pkg::CMD_READ, 1'h1);
    req(bpr_pkg::BPR_OP_ACTIVE, 2'h1, 1'h0, bpr_pkg::CMD_ACTIVE, 1'h0);
    req(bpr_pkg::BPR_OP_ACTIVE, 2'h0, 1'h0, bpr_pkg::CMD_ACTIVE, 1'h0);
    req(bpr_pkg::BPR_OP_WRITE, 2'h0, 1'h1, bpr_pkg::CMD_WRITE, 1'h1);
    req(bpr_pkg::BPR_OP_READ, 2'h1, 1'h0, bpr_pkg::CMD_READ, 1'h0);
    req(bpr_pkg::BPR_OP_PRE_ALL, 2'h2, 1'h0, bpr_pkg::CMD_PRECHARGE, 1'h1);
    req(bpr_pkg::BPR_OP_REFRESH, 2'h0, 1'h0, bpr_pkg::CMD_AUTO_REFRESH, 1'h0);
    req(bpr_pkg::BPR_OP_REFRESH, 2'h0, 1'h0, bpr_pkg::CMD_AUTO_REFRESH, 1'h0);
    req(bpr_pkg::BPR_OP_ACTIVE, 2'h2, 1'h0, bpr_pkg::CMD_ACTIVE, 1'h0);
    req(bpr_pkg::BPR_OP_PRE_ONE, 2'h2, 1'h0, bpr_pkg::CMD_PRECHARGE, 1'h0);
    step(10);
    check({all_idle, a_row}, 14'h2002);
    final_report();
  end

  // The tests need well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule
